// [csg_checker.sv]
// Port checker for the shutdown and gating control block.
// Assumes a bind to the design top; control words are shadowed from writes.
`timescale 1ns/100ps
module csg_checker
  import csg_pkg::*;
(
  // Clock and reset
  input wire logic            clk,
  input wire logic            sys_rst,
  // Register port
  input wire logic [3:0]      reg_addr,
  input wire logic [15:0]     reg_wdata,
  input wire logic            reg_wr,
  input wire logic            reg_rd,
  input wire logic [15:0]     reg_rdata,
  // Sources and time base
  input wire csg_src_type     shutdown_sources,
  input wire csg_cap_src_type capture_sources,
  input wire logic            time_base_reset,
  // Outputs
  input wire logic            pwm_shutdown,
  input wire logic            gate_active,
  input wire logic [5:0]      output_pin_enables,
  input wire logic            capture_input,
  input wire logic            aux_output
);
  logic [15:0] sdg_q;
  logic [15:0] out_q;
  wire  [7:0]  cap_v = capture_sources;
  wire         cap_sel = cap_v[out_q[2:0]];
  wire         req = (|(shutdown_sources & sdg_q[7:0])) | sdg_q[12];
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // Shadow of both control words
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      sdg_q <= 16'h0000;
      out_q <= 16'h0000;
    end
    else if (reg_wr && reg_addr == 4'h0)
      sdg_q <= reg_wdata;
    else if (reg_wr && reg_addr == 4'h1)
      out_q <= reg_wdata;
  end
  // Enables unsynchronised and unchanged for two samples
  sequence oe_settled;
    !out_q[15] ##1 (!out_q[15] && $stable(out_q[13:8]));
  endsequence
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
    else $error("read data outside its cycle");
  a_force_now: assert property (sdg_q[12] && !sdg_q[14] |-> ##[0:2] pwm_shutdown)
    else $error("forced shutdown late");
  a_gate_same: assert property (gate_active == pwm_shutdown)
    else $error("gate differs from shutdown");
  a_shut_cause: assert property ($rose(pwm_shutdown) |-> $past(req) || $past(req, 2))
    else $error("shutdown without request");
  a_sync_wait: assert property ($rose(pwm_shutdown) && sdg_q[14]
    |-> $past(time_base_reset) || $past(time_base_reset, 2))
    else $error("synced shutdown off time base");
  a_oe_direct: assert property (oe_settled |-> output_pin_enables == out_q[13:8])
    else $error("pin enables wrong");
  a_cap_select: assert property ($stable(out_q[2:0]) |-> capture_input == $past(cap_sel))
    else $error("capture source wrong");
  a_aux_roll: assert property (out_q[4:3] == 2'b01 && $stable(out_q[4:3])
    |-> aux_output == $past(time_base_reset))
    else $error("aux rollover wrong");
endmodule // csg_checker

bind csg_shutdown_gate_ctrl csg_checker csg_checker_inst (
  .clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .shutdown_sources(shutdown_sources), .capture_sources(capture_sources),
  .time_base_reset(time_base_reset), .pwm_shutdown(pwm_shutdown),
  .gate_active(gate_active), .output_pin_enables(output_pin_enables),
  .capture_input(capture_input), .aux_output(aux_output)
);

// [csg_far_model.sv]
// Far side: faults, comparators, cells and the time base pulse.
// Assumes the bench commands levels; lines follow one cycle later.
`timescale 1ns/100ps
module csg_far_model
(
  // Clock, reset and bench command
  input wire logic [0:0]  clk,
  input wire logic        sys_rst,
  input wire logic [15:0] cmd,
  // Lines toward the block
  output logic [15:0]     lines,
  output logic            tbr
);
  logic [2:0] cnt_q;
  // Levels lag the command; rollover every eight cycles
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      lines <= 16'h0000;
      cnt_q <= 3'h0;
      tbr   <= 1'b0;
    end
    else
    begin
      lines <= cmd;
      cnt_q <= cnt_q + 3'h1;
      tbr   <= cnt_q == 3'h7;
    end
  end
endmodule // csg_far_model

// [csg_map.svh]
// Register offsets, field positions, reset values and write masks for the
// capture/compare shutdown, gating and output steering control block.
// Assumes inclusion from the package and the design module only.
`ifndef CSG_MAP_SVH
`define CSG_MAP_SVH

`define CSG_ADDR_W          4
`define CSG_DATA_W          16
`define CSG_OFF_SDG_CTRL    4'h0
`define CSG_OFF_OUT_CTRL    4'h1
`define CSG_OFF_STATUS      4'h2
`define CSG_OFF_EVT_STAT    4'h3
`define CSG_OFF_EVT_MASK    4'h4
`define CSG_SDG_CTRL_MASK   16'hd0ff
`define CSG_OUT_CTRL_MASK   16'hbfdf
`define CSG_RST_VAL         16'h0000
`define CSG_B_RESTART       15
`define CSG_B_SYNC_MODE     14
`define CSG_B_SW_FORCE      12
`define CSG_B_OE_SYNC       15
`define CSG_B_GATE_ARM      10
`define CSG_B_SHUT_PROG     4
`define CSG_B_CAP_DIS       2
`define CSG_EVT_W           3
`define CSG_EVT_SHUT        0
`define CSG_EVT_CAPTURE     1
`define CSG_EVT_GATE        2

`endif

// [csg_pkg.sv]
// Types shared by the shutdown and gating control block.
// Assumes the map header supplies the register numbers; encodings and widths are set here.
`include "csg_map.svh"

package csg_pkg;

  // Shutdown and gating source inputs, bit order matches the enable field
  typedef struct packed {
    logic fault_input_b;
    logic fault_input_a;
    logic logic_cell_1;
    logic capture_pin_input;
    logic fault_input_d;
    logic fault_input_c;
    logic comparator_2;
    logic comparator_1;
  } csg_src_type;

  // Candidate capture inputs, bit index equals the source select code
  typedef struct packed {
    logic [3:0] logic_cell;
    logic [2:0] comparator;
    logic       capture_input_pin;
  } csg_cap_src_type;

  // Shutdown state machine
  typedef enum logic [2:0] {
    CSG_RUN     = 3'b001,
    CSG_PENDING = 3'b010,
    CSG_SHUT    = 3'b100
  } csg_state_type;

  // Capture gate mode encodings
  typedef enum logic [1:0] {
    CSG_GATE_LEVEL = 2'b00,
    CSG_GATE_RISE  = 2'b01,
    CSG_GATE_FALL  = 2'b10,
    CSG_GATE_RSVD  = 2'b11
  } csg_gate_mode_type;

  // Auxiliary output selection
  typedef enum logic [1:0] {
    CSG_AUX_OFF   = 2'b00,
    CSG_AUX_ROLL  = 2'b01,
    CSG_AUX_MODE  = 2'b10,
    CSG_AUX_EVENT = 2'b11
  } csg_aux_type;

endpackage : csg_pkg

// [csg_shutdown_gate_ctrl.sv]
// Shutdown, gating, output steering and capture source control of a
// capture/compare/PWM unit. Assumes the time base, compare datapath and pin
// logic are outside; all sources already share clk. Register port is plain.
//
// Notes on behaviour
// - Restart enabled: shutdown status clears at next period after input ends
// - Restart disabled: outputs stay shut until software clears the status
// - Sync mode set: shutdown or gate waits for time base reset or rollover
// - Software force acts like a hardware source, sync mode still applies
// - Each enable bit admits or ignores its own shutdown source
// - Enable bits: cmp1, cmp2, fault C, D, capture pin, cell 1, fault A, B
// - Unimplemented bits read zero, ignore writes; implemented bits reset zero
// - Output enable sync set: enable changes apply at time base reset
// - Output enable bit hands its pin to the unit, zero releases it
// - Only the multi-output unit implements enables B through F
// - Gate mode 00: high level enables capture, low disables; 11 reserved
// - Gate mode 01: rising edge clears capture disable, one shot
// - Gate mode 10: falling edge sets capture disable, one shot
// - Aux select: off, rollover pulse, mode signal, capture/compare event
// - Capture source: pin, comparators 1 to 3, logic cells 1 to 4
// - Writing gate arm arms one-shot gating in modes 01 or 10, reads zero
// - Capture disable set blocks capture events on the selected input
// - Shutdown status reads one while outputs are held in shutdown
`timescale 1ns/100ps
`include "csg_map.svh"

module csg_shutdown_gate_ctrl
  import csg_pkg::*;
#(
  parameter int MULTI_OUTPUT = 1
)
(
  // Clock and reset
  input  wire logic                   clk,
  input  wire logic                   sys_rst,
  // Register port
  input  wire logic [`CSG_ADDR_W-1:0] reg_addr,
  input  wire logic [`CSG_DATA_W-1:0] reg_wdata,
  input  wire logic                   reg_wr,
  input  wire logic                   reg_rd,
  output logic      [`CSG_DATA_W-1:0] reg_rdata,
  // Shutdown and gating sources
  input  wire csg_src_type            shutdown_sources,
  // Capture inputs and events from the datapath
  input  wire csg_cap_src_type        capture_sources,
  input  wire logic                   time_base_reset,
  input  wire logic                   mode_signal,
  input  wire logic                   compare_event,
  input  wire logic                   timer_mode,
  // Outputs to datapath and pins
  output logic                        pwm_shutdown,
  output logic                        gate_active,
  output logic [5:0]                  output_pin_enables,
  output logic                        capture_input,
  output logic                        capture_event,
  output logic                        aux_output,
  output logic                        irq
);

  // Elaboration check on the instance kind
  if (MULTI_OUTPUT != 0 && MULTI_OUTPUT != 1)
  begin : g_bad_param
    $error("MULTI_OUTPUT must be 0 or 1");
  end

  // Implemented output enable bits: A only unless multi-output
  localparam logic [5:0] OE_MASK = (MULTI_OUTPUT == 1) ? 6'h3f : 6'h01;

  // Registers
  logic [`CSG_DATA_W-1:0] sdg_ctrl_q;
  logic [`CSG_DATA_W-1:0] out_ctrl_q;
  logic [5:0]             oe_active_q;
  csg_state_type          state_q;
  csg_state_type          state_d;
  logic                   cap_dis_q;
  logic                   cap_dis_d;
  logic                   armed_q;
  logic                   armed_d;
  logic                   cap_prev_q;
  logic                   gate_prev_q;
  logic [`CSG_EVT_W-1:0]  evt_stat_q;
  logic [`CSG_EVT_W-1:0]  evt_mask_q;
  logic                   shut_prev_q;

  // Control fields
  wire logic              auto_restart_enable     = sdg_ctrl_q[`CSG_B_RESTART];
  wire logic              shutdown_gate_sync_mode = sdg_ctrl_q[`CSG_B_SYNC_MODE];
  wire logic              software_shutdown_force = sdg_ctrl_q[`CSG_B_SW_FORCE];
  wire logic [7:0]        shutdown_source_enables = sdg_ctrl_q[7:0];
  wire logic              output_enable_sync      = out_ctrl_q[`CSG_B_OE_SYNC];
  wire logic [5:0]        oe_written              = out_ctrl_q[13:8];
  wire csg_gate_mode_type capture_gate_mode       = csg_gate_mode_type'(out_ctrl_q[7:6]);
  wire csg_aux_type       aux_output_select       = csg_aux_type'(out_ctrl_q[4:3]);
  wire logic [2:0]        capture_source_select   = out_ctrl_q[2:0];

  // Bus decode
  wire logic wr_sdg    = reg_wr && (reg_addr == `CSG_OFF_SDG_CTRL);
  wire logic wr_out    = reg_wr && (reg_addr == `CSG_OFF_OUT_CTRL);
  wire logic wr_status = reg_wr && (reg_addr == `CSG_OFF_STATUS);
  wire logic wr_mask   = reg_wr && (reg_addr == `CSG_OFF_EVT_MASK);
  wire logic rd_evt    = reg_rd && (reg_addr == `CSG_OFF_EVT_STAT);

  // Combined request from enabled sources and the software force
  wire logic shutdown_request =
    (|(shutdown_sources & shutdown_source_enables))
    || software_shutdown_force;

  // Software clear of the shutdown status and gate arm request
  wire logic sw_clear_shut = wr_status && !reg_wdata[`CSG_B_SHUT_PROG];
  wire logic gate_arm_req  = wr_status && reg_wdata[`CSG_B_GATE_ARM];

  // Shutdown state machine
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      CSG_RUN:
      begin
        if (shutdown_request && shutdown_gate_sync_mode && !time_base_reset)
          state_d = CSG_PENDING;
        else if (shutdown_request)
          state_d = CSG_SHUT;
      end
      CSG_PENDING:
      begin
        if (!shutdown_request)
          state_d = CSG_RUN;
        else if (time_base_reset)
          state_d = CSG_SHUT;
      end
      CSG_SHUT:
      begin
        if (auto_restart_enable && !shutdown_request && time_base_reset)
          state_d = CSG_RUN;
        else if (!auto_restart_enable && !shutdown_request && sw_clear_shut)
          state_d = CSG_RUN;
      end
      default:
        state_d = CSG_RUN;
    endcase
  end

  wire logic shut_next = (state_d == CSG_SHUT);

  // Capture source selection
  wire logic [7:0] cap_vec      = capture_sources;
  wire logic       cap_selected = cap_vec[capture_source_select];
  wire logic       gate_level   = (state_q == CSG_SHUT);
  wire logic       gate_rise    = gate_level && !gate_prev_q;
  wire logic       gate_fall    = !gate_level && gate_prev_q;

  // Capture disable status
  always_comb
  begin
    cap_dis_d = cap_dis_q;
    armed_d   = armed_q || gate_arm_req;
    case (capture_gate_mode)
      CSG_GATE_LEVEL:
        cap_dis_d = !gate_level;
      CSG_GATE_RISE:
        if (armed_q && gate_rise)
        begin
          cap_dis_d = 1'b0;
          armed_d   = 1'b0;
        end
      CSG_GATE_FALL:
        if (armed_q && gate_fall)
        begin
          cap_dis_d = 1'b1;
          armed_d   = 1'b0;
        end
      default:
        cap_dis_d = cap_dis_q; // Reserved mode holds state
    endcase
  end

  // Capture edge on selected input, blocked while disabled
  wire logic cap_edge = cap_selected && !cap_prev_q && !cap_dis_q;

  // Auxiliary output selection
  wire logic aux_d =
    (aux_output_select == CSG_AUX_ROLL)  ? time_base_reset :
    (aux_output_select == CSG_AUX_MODE)  ? mode_signal :
    (aux_output_select == CSG_AUX_EVENT) ? ((cap_edge || compare_event) && !timer_mode) :
    1'b0;

  // Output enables, synchronised when asked
  wire logic [5:0] oe_d = (output_enable_sync && !time_base_reset) ?
                          oe_active_q : (oe_written & OE_MASK);

  // Event status: shutdown entry, capture event, gate event
  wire logic [`CSG_EVT_W-1:0] evt_set = {gate_rise,
                                         cap_edge,
                                         shut_next && !shut_prev_q};
  wire logic [`CSG_EVT_W-1:0] evt_d = (rd_evt ? '0 : evt_stat_q) | evt_set;

  // Status read value
  wire logic [`CSG_DATA_W-1:0] status_rd =
    ({{(`CSG_DATA_W-1){1'b0}}, (state_q == CSG_SHUT)} << `CSG_B_SHUT_PROG) |
    ({{(`CSG_DATA_W-1){1'b0}}, cap_dis_q} << `CSG_B_CAP_DIS);

  // Read mux
  wire logic [`CSG_DATA_W-1:0] rdata_d =
    !reg_rd                              ? `CSG_RST_VAL :
    (reg_addr == `CSG_OFF_SDG_CTRL)      ? sdg_ctrl_q :
    (reg_addr == `CSG_OFF_OUT_CTRL)      ? out_ctrl_q :
    (reg_addr == `CSG_OFF_STATUS)        ? status_rd :
    (reg_addr == `CSG_OFF_EVT_STAT)      ? {{(`CSG_DATA_W-`CSG_EVT_W){1'b0}}, evt_stat_q} :
    (reg_addr == `CSG_OFF_EVT_MASK)      ? {{(`CSG_DATA_W-`CSG_EVT_W){1'b0}}, evt_mask_q} :
    `CSG_RST_VAL;

  // Control registers
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      sdg_ctrl_q <= `CSG_RST_VAL;
      out_ctrl_q <= `CSG_RST_VAL;
      evt_mask_q <= '0;
    end
    else
    begin
      if (wr_sdg)
        sdg_ctrl_q <= reg_wdata & `CSG_SDG_CTRL_MASK;
      if (wr_out)
        out_ctrl_q <= reg_wdata & `CSG_OUT_CTRL_MASK & {2'b11, OE_MASK, 8'hff};
      if (wr_mask)
        evt_mask_q <= reg_wdata[`CSG_EVT_W-1:0];
    end
  end

  // Behaviour state
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state_q     <= CSG_RUN;
      cap_dis_q   <= 1'b0;
      armed_q     <= 1'b0;
      cap_prev_q  <= 1'b0;
      gate_prev_q <= 1'b0;
      shut_prev_q <= 1'b0;
      evt_stat_q  <= '0;
      oe_active_q <= '0;
    end
    else
    begin
      state_q     <= state_d;
      cap_dis_q   <= cap_dis_d;
      armed_q     <= armed_d;
      cap_prev_q  <= cap_selected;
      gate_prev_q <= gate_level;
      shut_prev_q <= shut_next;
      evt_stat_q  <= evt_d; // Set wins over read clear
      oe_active_q <= oe_d;
    end
  end

  // Registered outputs
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      reg_rdata          <= '0;
      pwm_shutdown       <= 1'b0;
      gate_active        <= 1'b0;
      output_pin_enables <= '0;
      capture_input      <= 1'b0;
      capture_event      <= 1'b0;
      aux_output         <= 1'b0;
      irq                <= 1'b0;
    end
    else
    begin
      reg_rdata          <= rdata_d;
      pwm_shutdown       <= shut_next;
      gate_active        <= shut_next;
      output_pin_enables <= oe_d;
      capture_input      <= cap_selected;
      capture_event      <= cap_edge;
      aux_output         <= aux_d;
      irq                <= |(evt_d & evt_mask_q);
    end
  end

endmodule // csg_shutdown_gate_ctrl

// [tb_top.sv]
// Bench for the shutdown and gating control block.
// Assumes a 10 MHz clock and read data one cycle after the strobe.
`timescale 1ns/100ps
module tb_top;
  logic        clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic [3:0]  reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [15:0] cmd = 16'h0000;
  logic [15:0] d;
  wire  [15:0] reg_rdata;
  wire  [15:0] far;
  wire  [5:0]  oe;
  wire         tbr, shut, cap_in, irq, cap_ev;
  int          error_cnt = 0;
  int          cmp_count = 0;
  int          cyc = 0;
  // Clock of 100 ns period
  always #50 clk = ~clk;
  // Far side and block
  csg_far_model csg_far_model_inst (.clk(clk), .sys_rst(sys_rst), .cmd(cmd),
    .lines(far), .tbr(tbr));
  csg_shutdown_gate_ctrl csg_shutdown_gate_ctrl_inst (.clk(clk), .sys_rst(sys_rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .shutdown_sources(far[7:0]), .capture_sources(far[15:8]),
    .time_base_reset(tbr), .mode_signal(1'b0), .compare_event(1'b0),
    .timer_mode(1'b0), .pwm_shutdown(shut), .gate_active(), .output_pin_enables(oe),
    .capture_input(cap_in), .capture_event(cap_ev), .aux_output(), .irq(irq));
  task automatic end_of_test();
    $display("compares %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [3:0] a, output logic [15:0] v);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(posedge clk);
    v = reg_rdata;
  endtask
  task automatic rc(input logic [3:0] a, input logic [15:0] exp);
    logic [15:0] v;
    rd(a, v);
    chk(v, exp);
  endtask
  // Hang guard
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      error_cnt++;
      end_of_test();
    end
  end
  // Main sequence
  initial
  begin
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    for (int i = 0; i < 6; i++)
      rc(4'(i), (i == 2) ? 16'h0004 : 16'h0000);
    wr(4'h0, 16'hffff);
    rc(4'h0, 16'hd0ff);
    wr(4'h1, 16'hffff);
    rc(4'h1, 16'hbfdf);
    wr(4'h5, 16'hffff);
    rc(4'h5, 16'h0000);
    wr(4'h0, 16'h0000);
    wr(4'h1, 16'h0000);
    wr(4'h2, 16'h0000);
    rd(4'h3, d);
    $display("test registers done");
    wr(4'h4, 16'h0001);
    wr(4'h0, 16'h1000);
    tick(3);
    chk({15'h0, shut}, 16'h0001);
    chk({15'h0, irq}, 16'h0001);
    rd(4'h2, d);
    chk(d & 16'h0010, 16'h0010);
    wr(4'h0, 16'h0000);
    tick(20);
    chk({15'h0, shut}, 16'h0001);
    wr(4'h2, 16'h0000);
    tick(3);
    chk({15'h0, shut}, 16'h0000);
    rd(4'h3, d);
    chk(d & 16'h0001, 16'h0001);
    tick(2);
    chk({15'h0, irq}, 16'h0000);
    $display("test force done");
    for (int i = 0; i < 8; i++)
    begin
      wr(4'h0, 16'h8000 | 16'(1 << i));
      cmd <= {8'h00, ~(8'h01 << i)};
      tick(12);
      chk({15'h0, shut}, 16'h0000);
      cmd <= 16'h00ff;
      tick(4);
      chk({15'h0, shut}, 16'h0001);
      cmd <= 16'h0000;
      tick(12);
      chk({15'h0, shut}, 16'h0000);
    end
    wr(4'h0, 16'h5000);
    tick(12);
    chk({15'h0, shut}, 16'h0001);
    wr(4'h0, 16'h0000);
    wr(4'h2, 16'h0000);
    $display("test sources done");
    wr(4'h1, 16'h3f00);
    tick(2);
    chk({10'h0, oe}, 16'h003f);
    wr(4'h1, 16'h8500);
    tick(12);
    chk({10'h0, oe}, 16'h0005);
    for (int i = 0; i < 8; i++)
    begin
      wr(4'h1, {11'h0, i[1:0], i[2:0]});
      cmd <= 16'(16'h0100 << i);
      tick(3);
      chk({15'h0, cap_in}, 16'h0001);
      cmd <= 16'h0000;
    end
    $display("test outputs done");
    wr(4'h1, 16'h0040);
    wr(4'h2, 16'h0400);
    wr(4'h0, 16'h1000);
    tick(3);
    rd(4'h2, d);
    chk(d & 16'h0404, 16'h0000);
    cmd <= 16'h0100;
    tick(3);
    chk({15'h0, cap_ev}, 16'h0001);
    cmd <= 16'h0000;
    wr(4'h1, 16'h0080);
    wr(4'h2, 16'h0400);
    wr(4'h0, 16'h0000);
    wr(4'h2, 16'h0000);
    tick(3);
    rd(4'h2, d);
    chk(d & 16'h0404, 16'h0004);
    cmd <= 16'h0100;
    tick(3);
    chk({15'h0, cap_ev}, 16'h0000);
    cmd <= 16'h0000;
    $display("test gating done");
    end_of_test();
  end
endmodule // tb_top
